// ==== core/fpaf_core.sv ====
// Functional notes
// - Complement bit set protects exactly the inverse of the selected range.
// - Erase or program touching any protected part is ignored; block erases of the bottom or top block check only that block's own lock bit.
// - Lock bits govern writes only when scheme select is one.
// - All lock bits come up set after power up.
// - Upper-address byte applies only in three-byte mode.
// - Bit 0 of the upper byte, as address bit 24, picks lower or upper half.
// - Four-byte mode after power-on bit or enter opcode ignores upper byte.
// - Any four-byte address in a frame ending on a byte boundary overwrites the upper byte with its top byte.
// - Upper byte clears on power up and on reset.
// - Chip select low starts an instruction; first byte is the opcode.
// - Serial input is sampled on rising link clock, MSB first.
// - Chip select rising ends the instruction; reads may end anywhere.
// - Writes ending off a byte boundary are discarded.
// - While busy only status reads are honoured.
// - Scheme select zero uses complement, top/bottom and extent bits.
// - Power-on address bit chooses starting address mode.
//
// Top of the protection and address framing logic
// Assumes the SPI pins are asynchronous to clk_sys and much slower
`timescale 1ns/1ps
module fpaf_core (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic serial_in,
	input wire logic protect_scheme_sel,
	input wire logic protect_invert,
	input wire logic protect_from_bottom,
	input wire logic [3:0] protect_extent,
	input wire logic addr_mode_at_power_on,
	input wire logic op_busy,
	output logic addr_mode_now,
	output logic [7:0] address_top_byte,
	output logic write_enabled,
	output logic cmd_valid,
	output logic [7:0] cmd_opcode,
	output logic [31:0] cmd_address,
	output logic [2:0] cmd_kind,
	output logic cmd_rejected,
	output logic status_read_start
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic cs_level;
	logic cs_rise;
	logic cs_fall;
	logic clk_rise;
	logic din_level;

	fpaf_pin_sync u_cs (.clk_sys(clk_sys), .rst_n(rst_n), .pin(cs_n),
		.level(cs_level), .rise(cs_rise), .fall(cs_fall));
	fpaf_pin_sync u_clk (.clk_sys(clk_sys), .rst_n(rst_n), .pin(sclk),
		.level(), .rise(clk_rise), .fall());
	fpaf_pin_sync u_din (.clk_sys(clk_sys), .rst_n(rst_n), .pin(serial_in),
		.level(din_level), .rise(), .fall());

	// ****************************************
	// Shift and frame state
	// ****************************************
	fpaf_pkg::fpaf_phase_t phase;
	logic [7:0] shreg;
	logic [2:0] bit_cnt;
	logic [7:0] opcode;
	logic [2:0] addr_bytes_got;
	logic [31:0] addr_acc;
	logic [7:0] data_bytes;
	logic ignore_frame;
	logic power_up_done;
	logic [fpaf_pkg::LOCK_COUNT-1:0] lock_bits;

	function automatic logic is_write_op(input logic [7:0] op);
		is_write_op = (op == fpaf_pkg::OP_PROG3) || (op == fpaf_pkg::OP_PROG4) ||
			(op == fpaf_pkg::OP_SE3) || (op == fpaf_pkg::OP_SE4) ||
			(op == fpaf_pkg::OP_BE32) || (op == fpaf_pkg::OP_BE64_3) ||
			(op == fpaf_pkg::OP_BE64_4) || (op == fpaf_pkg::OP_CE1) ||
			(op == fpaf_pkg::OP_CE2) || (op == fpaf_pkg::OP_WR_STATUS1) ||
			(op == fpaf_pkg::OP_WR_STATUS2) || (op == fpaf_pkg::OP_WR_STATUS3) ||
			(op == fpaf_pkg::OP_WR_XADDR) || (op == fpaf_pkg::OP_WR_EN) ||
			(op == fpaf_pkg::OP_WR_DIS) || (op == fpaf_pkg::OP_LOCK3) ||
			(op == fpaf_pkg::OP_UNLOCK3) || (op == fpaf_pkg::OP_GLOBAL_LOCK) ||
			(op == fpaf_pkg::OP_GLOBAL_UNLOCK);
	endfunction

	function automatic logic is_four_byte_op(input logic [7:0] op);
		is_four_byte_op = (op == fpaf_pkg::OP_PROG4) || (op == fpaf_pkg::OP_SE4) ||
			(op == fpaf_pkg::OP_BE64_4) || (op == fpaf_pkg::OP_READ4);
	endfunction

	function automatic logic has_addr(input logic [7:0] op);
		has_addr = is_four_byte_op(op) || (op == fpaf_pkg::OP_PROG3) ||
			(op == fpaf_pkg::OP_SE3) || (op == fpaf_pkg::OP_BE32) ||
			(op == fpaf_pkg::OP_BE64_3) || (op == fpaf_pkg::OP_READ3) ||
			(op == fpaf_pkg::OP_LOCK3) || (op == fpaf_pkg::OP_UNLOCK3);
	endfunction

	function automatic logic [2:0] kind_of(input logic [7:0] op);
		case (op)
			fpaf_pkg::OP_PROG3, fpaf_pkg::OP_PROG4: kind_of = fpaf_pkg::KIND_PROG;
			fpaf_pkg::OP_SE3, fpaf_pkg::OP_SE4: kind_of = fpaf_pkg::KIND_SECTOR;
			fpaf_pkg::OP_BE32: kind_of = fpaf_pkg::KIND_BLK32;
			fpaf_pkg::OP_BE64_3, fpaf_pkg::OP_BE64_4: kind_of = fpaf_pkg::KIND_BLK64;
			fpaf_pkg::OP_CE1, fpaf_pkg::OP_CE2: kind_of = fpaf_pkg::KIND_CHIP;
			default: kind_of = fpaf_pkg::KIND_NONE;
		endcase
	endfunction

	// ****************************************
	// Decode of the current frame
	// ****************************************
	logic byte_done;
	logic [7:0] next_byte;
	logic [2:0] need_bytes;
	logic four_byte_frame;
	logic [31:0] eff_addr;
	logic [fpaf_pkg::BLOCK_W-1:0] tgt_block;
	logic [3:0] tgt_sector;
	logic on_boundary;

	assign byte_done = clk_rise && !cs_level && (bit_cnt == 3'h7);
	assign next_byte = {shreg[6:0], din_level};
	assign four_byte_frame = addr_mode_now || is_four_byte_op(opcode);
	assign need_bytes = four_byte_frame ? 3'h4 : 3'h3;
	// Upper byte only extends three-byte addresses
	assign eff_addr = four_byte_frame ? addr_acc :
		{7'h00, address_top_byte[0], addr_acc[23:0]};
	assign tgt_block = eff_addr[24:16];
	assign tgt_sector = eff_addr[15:12];
	assign on_boundary = (bit_cnt == 3'h0);

	// ****************************************
	// Protection check
	// ****************************************
	logic [fpaf_pkg::BLOCK_W-1:0] rng_lo;
	logic [fpaf_pkg::BLOCK_W-1:0] rng_hi;
	logic rng_none;
	logic [2:0] kind;
	logic [fpaf_pkg::BLOCK_W-1:0] span_lo;
	logic [fpaf_pkg::BLOCK_W-1:0] span_hi;
	logic range_hit;
	logic lock_hit;
	logic protected_hit;
	logic edge_block;
	logic blk_lock;
	logic sec_lock;
	logic any_lock;
	logic [5:0] sec_base;

	fpaf_range_decode u_range (.protect_invert(protect_invert),
		.protect_from_bottom(protect_from_bottom), .protect_extent(protect_extent),
		.lo_block(rng_lo), .hi_block(rng_hi), .none(rng_none));

	assign kind = kind_of(opcode);
	assign span_lo = (kind == fpaf_pkg::KIND_CHIP) ? 9'h000 : tgt_block;
	assign span_hi = (kind == fpaf_pkg::KIND_CHIP) ? 9'h1FF : tgt_block;
	assign range_hit = !rng_none && (span_lo <= rng_hi) && (span_hi >= rng_lo);
	// Bottom and top blocks are locked per 4 KB sector
	assign edge_block = (tgt_block == 9'h000) || (tgt_block == 9'h1FF);
	assign sec_base = (tgt_block == 9'h000) ? 6'h00 : 6'(fpaf_pkg::LOCK_SECTORS);
	assign blk_lock = lock_bits[tgt_block];
	assign sec_lock = lock_bits[10'h200 + 10'(sec_base) + 10'(tgt_sector)];
	assign any_lock = |lock_bits;
	assign lock_hit = (kind == fpaf_pkg::KIND_CHIP) ? any_lock :
		(edge_block && kind <= fpaf_pkg::KIND_SECTOR) ? sec_lock : blk_lock;
	assign protected_hit = protect_scheme_sel ? lock_hit : range_hit;

	// ****************************************
	// Frame sequencing
	// ****************************************
	logic frame_end;
	logic frame_whole;
	logic accept;

	assign frame_end = cs_rise && !ignore_frame && (phase != fpaf_pkg::FPAF_OPCODE);
	assign frame_whole = frame_end && on_boundary;
	// Latched writes need a whole byte count; busy frames never end
	assign accept = frame_whole && write_enabled;

	always_ff @(posedge clk_sys) begin
		if (!rst_n || cs_level) begin
			bit_cnt <= 3'h0;
			shreg <= 8'h00;
		end else if (clk_rise) begin
			bit_cnt <= bit_cnt + 3'h1;
			shreg <= next_byte;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			phase <= fpaf_pkg::FPAF_OPCODE;
			opcode <= 8'h00;
			addr_bytes_got <= 3'h0;
			addr_acc <= 32'h0000_0000;
			data_bytes <= 8'h00;
			ignore_frame <= 1'b0;
		end else if (cs_fall) begin
			phase <= fpaf_pkg::FPAF_OPCODE;
			addr_bytes_got <= 3'h0;
			addr_acc <= 32'h0000_0000;
			data_bytes <= 8'h00;
			ignore_frame <= 1'b0;
		end else if (byte_done) begin
			case (phase)
				fpaf_pkg::FPAF_OPCODE: begin
					opcode <= next_byte;
					ignore_frame <= op_busy && (next_byte != fpaf_pkg::OP_RD_STATUS1) &&
						(next_byte != fpaf_pkg::OP_RD_STATUS2) &&
						(next_byte != fpaf_pkg::OP_RD_STATUS3);
					phase <= has_addr(next_byte) ? fpaf_pkg::FPAF_ADDR : fpaf_pkg::FPAF_DATA;
				end
				fpaf_pkg::FPAF_ADDR: begin
					addr_acc <= {addr_acc[23:0], next_byte};
					addr_bytes_got <= addr_bytes_got + 3'h1;
					if (addr_bytes_got + 3'h1 == need_bytes) begin
						phase <= fpaf_pkg::FPAF_DATA;
					end
				end
				fpaf_pkg::FPAF_DATA: begin
					data_bytes <= next_byte;
				end
				default: phase <= fpaf_pkg::FPAF_OPCODE;
			endcase
		end
	end

	// ****************************************
	// Address mode and upper-address byte
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			power_up_done <= 1'b0;
			addr_mode_now <= 1'b0;
			address_top_byte <= fpaf_pkg::XADDR_RESET;
		end else if (!power_up_done) begin
			power_up_done <= 1'b1;
			addr_mode_now <= addr_mode_at_power_on;
		end else if (frame_whole && opcode == fpaf_pkg::OP_ENTER_4B) begin
			addr_mode_now <= 1'b1;
		end else if (frame_whole && opcode == fpaf_pkg::OP_EXIT_4B) begin
			addr_mode_now <= 1'b0;
		end else if (accept && opcode == fpaf_pkg::OP_WR_XADDR &&
			phase == fpaf_pkg::FPAF_DATA) begin
			address_top_byte <= data_bytes;
		end else if (frame_end && on_boundary && phase == fpaf_pkg::FPAF_DATA &&
			has_addr(opcode) && four_byte_frame) begin
			address_top_byte <= addr_acc[31:24];
		end
	end

	// ****************************************
	// Write latch, locks and command output
	// ****************************************
	logic exec_write;
	logic is_array_op;

	assign is_array_op = (kind != fpaf_pkg::KIND_NONE);
	assign exec_write = accept && (!is_array_op || !protected_hit);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			lock_bits <= '1;
		end else if (accept && opcode == fpaf_pkg::OP_GLOBAL_LOCK) begin
			lock_bits <= '1;
		end else if (accept && opcode == fpaf_pkg::OP_GLOBAL_UNLOCK) begin
			lock_bits <= '0;
		end else if (accept && phase == fpaf_pkg::FPAF_DATA &&
			(opcode == fpaf_pkg::OP_LOCK3 || opcode == fpaf_pkg::OP_UNLOCK3)) begin
			if (edge_block) begin
				lock_bits[10'h200 + 10'(sec_base) + 10'(tgt_sector)] <=
					(opcode == fpaf_pkg::OP_LOCK3);
			end else begin
				lock_bits[tgt_block] <= (opcode == fpaf_pkg::OP_LOCK3);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			write_enabled <= 1'b0;
		end else if (frame_end && on_boundary && opcode == fpaf_pkg::OP_WR_EN) begin
			write_enabled <= 1'b1;
		end else if (frame_end && on_boundary && is_write_op(opcode)) begin
			write_enabled <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cmd_valid <= 1'b0;
			cmd_opcode <= 8'h00;
			cmd_address <= 32'h0000_0000;
			cmd_kind <= fpaf_pkg::KIND_NONE;
			cmd_rejected <= 1'b0;
			status_read_start <= 1'b0;
		end else begin
			cmd_valid <= exec_write && is_array_op && phase == fpaf_pkg::FPAF_DATA;
			cmd_rejected <= accept && is_array_op && protected_hit &&
				phase == fpaf_pkg::FPAF_DATA;
			status_read_start <= byte_done && phase == fpaf_pkg::FPAF_OPCODE &&
				(next_byte == fpaf_pkg::OP_RD_STATUS1);
			if (frame_end) begin
				cmd_opcode <= opcode;
				cmd_address <= eff_addr;
				cmd_kind <= kind;
			end
		end
	end
endmodule

// ==== core/fpaf_pkg.sv ====
// Constants for the flash protection and address framing block
// Assumes a 40 MHz system clock and an SPI host clocked far slower
package fpaf_pkg;
	localparam int CLK_SYS_HZ = 40000000;
	localparam int BLOCK_W = 9;
	localparam int SECTOR_W = 4;
	localparam int ADDR_W = 32;
	localparam int LOCK_SECTORS = 16;
	localparam int LOCK_COUNT = 512 + 2 * LOCK_SECTORS;
	localparam logic [7:0] XADDR_RESET = 8'h00;
	localparam logic [7:0] OP_WR_EN = 8'h06;
	localparam logic [7:0] OP_WR_DIS = 8'h04;
	localparam logic [7:0] OP_RD_STATUS1 = 8'h05;
	localparam logic [7:0] OP_RD_STATUS2 = 8'h35;
	localparam logic [7:0] OP_RD_STATUS3 = 8'h15;
	localparam logic [7:0] OP_WR_STATUS1 = 8'h01;
	localparam logic [7:0] OP_WR_STATUS2 = 8'h31;
	localparam logic [7:0] OP_WR_STATUS3 = 8'h11;
	localparam logic [7:0] OP_WR_XADDR = 8'hC5;
	localparam logic [7:0] OP_ENTER_4B = 8'hB7;
	localparam logic [7:0] OP_EXIT_4B = 8'hE9;
	localparam logic [7:0] OP_PROG3 = 8'h02;
	localparam logic [7:0] OP_PROG4 = 8'h12;
	localparam logic [7:0] OP_SE3 = 8'h20;
	localparam logic [7:0] OP_SE4 = 8'h21;
	localparam logic [7:0] OP_BE32 = 8'h52;
	localparam logic [7:0] OP_BE64_3 = 8'hD8;
	localparam logic [7:0] OP_BE64_4 = 8'hDC;
	localparam logic [7:0] OP_CE1 = 8'hC7;
	localparam logic [7:0] OP_CE2 = 8'h60;
	localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7E;
	localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
	localparam logic [7:0] OP_LOCK3 = 8'h36;
	localparam logic [7:0] OP_UNLOCK3 = 8'h39;
	localparam logic [7:0] OP_READ3 = 8'h03;
	localparam logic [7:0] OP_READ4 = 8'h13;
	localparam logic [3:0] EXTENT_HALF = 4'h9;
	localparam logic [2:0] KIND_NONE = 3'h0;
	localparam logic [2:0] KIND_PROG = 3'h1;
	localparam logic [2:0] KIND_SECTOR = 3'h2;
	localparam logic [2:0] KIND_BLK32 = 3'h3;
	localparam logic [2:0] KIND_BLK64 = 3'h4;
	localparam logic [2:0] KIND_CHIP = 3'h5;
	typedef enum logic [1:0] {FPAF_OPCODE, FPAF_ADDR, FPAF_DATA} fpaf_phase_t;
endpackage

// ==== core/fpaf_pin_sync.sv ====
// Two-stage synchroniser with an edge finder behind the second stage
// Assumes the input changes slowly next to clk_sys
`timescale 1ns/1ps
module fpaf_pin_sync (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic pin,
	output logic level,
	output logic rise,
	output logic fall
);
	logic stage1;
	logic stage2;
	logic stage3;
	logic armed;
	// Stages track the pin through reset, so no false edge follows it
	always_ff @(posedge clk_sys) begin
		stage1 <= pin;
		stage2 <= stage1;
		stage3 <= stage2;
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			armed <= 1'b0;
		end else begin
			armed <= 1'b1;
		end
	end
	assign level = stage2;
	assign rise = armed & stage2 & ~stage3;
	assign fall = armed & ~stage2 & stage3;
endmodule

// ==== core/fpaf_range_decode.sv ====
// Range protection decode for the status-bit scheme
// Assumes a 512-block array of 64 KB blocks
`timescale 1ns/1ps
module fpaf_range_decode (
	input wire logic protect_invert,
	input wire logic protect_from_bottom,
	input wire logic [3:0] protect_extent,
	output logic [fpaf_pkg::BLOCK_W-1:0] lo_block,
	output logic [fpaf_pkg::BLOCK_W-1:0] hi_block,
	output logic none
);
	logic all_codes;
	logic [fpaf_pkg::BLOCK_W:0] count;
	logic [fpaf_pkg::BLOCK_W-1:0] raw_lo;
	logic [fpaf_pkg::BLOCK_W-1:0] raw_hi;
	logic raw_none;
	logic raw_all;
	assign all_codes = protect_extent > fpaf_pkg::EXTENT_HALF;
	assign count = (10'h001 << (protect_extent - 4'h1));
	assign raw_none = (protect_extent == 4'h0);
	assign raw_all = all_codes;
	assign raw_lo = protect_from_bottom ? 9'h000 : 9'(10'h200 - count);
	assign raw_hi = protect_from_bottom ? 9'(count - 10'h001) : 9'h1FF;
	// Complement of a bottom range is the top remainder and vice versa
	assign none = protect_invert ? raw_all : raw_none;
	assign lo_block = protect_invert ? (raw_none ? 9'h000 : (protect_from_bottom ?
		9'(raw_hi + 9'h001) : 9'h000)) : (raw_all ? 9'h000 : raw_lo);
	assign hi_block = protect_invert ? (raw_none ? 9'h1FF : (protect_from_bottom ?
		9'h1FF : 9'(raw_lo - 9'h001))) : (raw_all ? 9'h1FF : raw_hi);
endmodule

// ==== test/fpaf_assertions.sv ====
// Checker on the ports of the protection and framing block
// Assumes binding to fpaf_core and one clk_sys domain
`timescale 1ns/1ps
module fpaf_assertions (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic op_busy,
	input wire logic addr_mode_at_power_on,
	input wire logic addr_mode_now,
	input wire logic [7:0] address_top_byte,
	input wire logic write_enabled,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_opcode,
	input wire logic [31:0] cmd_address,
	input wire logic [2:0] cmd_kind,
	input wire logic cmd_rejected
);
	// ****************
	// Port relations
	// ****************
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_busy_hold;
		op_busy [*8];
	endsequence
	sequence s_answer;
		cmd_valid || cmd_rejected;
	endsequence
	a_no_double_pulse: assert property (!(cmd_valid && cmd_rejected))
		else $error("accept and reject pulses together");
	a_answer_after_end: assert property (s_answer |-> $past(cs_n) && $past(cs_n, 2)
		&& $past(cs_n, 3)) else $error("answer while frame open");
	a_latch_used: assert property (s_answer |-> $past(write_enabled) && !write_enabled)
		else $error("array op without write latch");
	a_busy_blocks: assert property (s_busy_hold |-> !cmd_valid && !cmd_rejected)
		else $error("array op taken while busy");
	a_mode_at_end: assert property ($changed(addr_mode_now) && $past(rst_n, 2) |-> cs_n)
		else $error("address mode changed inside frame");
	a_reset_clears: assert property ($rose(rst_n) |-> address_top_byte == 8'h00
		&& !addr_mode_now && !write_enabled) else $error("outputs not cleared by reset");
	a_power_mode: assert property ($rose(rst_n) |=> addr_mode_now == $past(addr_mode_at_power_on))
		else $error("start mode differs from power-on bit");
	a_ext_applied: assert property (cmd_valid && !addr_mode_now && cmd_opcode == 8'h20
		|-> cmd_address[31:24] == {7'h00, address_top_byte[0]})
		else $error("upper byte not applied");
	a_top_replaced: assert property (cmd_valid && addr_mode_now && cmd_kind != 3'h5
		|=> address_top_byte == $past(cmd_address[31:24])) else $error("upper byte not replaced");
endmodule
bind fpaf_core fpaf_assertions u_chk (.*);

// ==== test/fpaf_host_model.sv ====
// SPI host model driving chip select, clock and data
// Assumes mode 0 framing with a 200 ns link clock
`timescale 1ns/1ps
module fpaf_host_model (
	output logic cs_n,
	output logic sclk,
	output logic serial_in
);
	// ****************
	// Frame driver
	// ****************
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		serial_in = 1'b0;
	end
	task automatic frame(input logic [63:0] bits_v, input int nbits);
		cs_n = 1'b0;
		#100;
		for (int i = nbits - 1; i >= 0; i--) begin
			serial_in = bits_v[i];
			#100 sclk = 1'b1;
			#100 sclk = 1'b0;
		end
		#100 cs_n = 1'b1;
		serial_in = ~serial_in;
		#300;
	endtask
endmodule

// ==== test/fpaf_core_tb.sv ====
// Self-checking bench for the protection and framing block
// Assumes the host model and checker files compiled before it
`timescale 1ns/1ps
module fpaf_core_tb;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic cs_n, sclk, serial_in;
	logic protect_scheme_sel = 1'b0, protect_invert = 1'b0, protect_from_bottom = 1'b0;
	logic [3:0] protect_extent = 4'h0;
	logic addr_mode_at_power_on = 1'b0, op_busy = 1'b0;
	logic addr_mode_now, write_enabled, cmd_valid, cmd_rejected, status_read_start;
	logic [7:0] address_top_byte, cmd_opcode;
	logic [31:0] cmd_address, ra;
	logic [2:0] cmd_kind;
	logic [7:0] ops[5] = '{8'h12, 8'h21, 8'h52, 8'hDC, 8'hC7};
	int lens[5] = '{48, 40, 40, 40, 8};
	int failures = 0, n_checks = 0, n_val = 0, n_rej = 0, n_stat = 0;
	int seed = 32'h62d82b7f;
	// ****************
	// Harness
	// ****************
	always #12.5 clk_sys = ~clk_sys;
	fpaf_host_model u_host (.cs_n(cs_n), .sclk(sclk), .serial_in(serial_in));
	fpaf_core u_dut (.*);
	always @(posedge clk_sys) begin
		if (cmd_valid === 1'b1) n_val++;
		if (cmd_rejected === 1'b1) n_rej++;
		if (status_read_start === 1'b1) n_stat++;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	function automatic logic prot(input logic [8:0] blk);
		int n;
		n = protect_extent == 4'h0 ? 0 : protect_extent >= 4'hA ? 512 : 1 << (protect_extent - 1);
		return protect_invert ^ (protect_from_bottom ? blk < n : blk >= 512 - n);
	endfunction
	task automatic setp(input logic w, input logic i, input logic b, input logic [3:0] e);
		@(posedge clk_sys);
		#2;
		protect_scheme_sel = w;
		protect_invert = i;
		protect_from_bottom = b;
		protect_extent = e;
	endtask
	// Outcome code: 0 none, 1 accepted, 2 rejected
	task automatic op(input logic [63:0] b, input int nb, input int exp);
		int v, r;
		v = n_val;
		r = n_rej;
		u_host.frame(64'h06, 8);
		u_host.frame(b, nb);
		check("outcome", (n_val - v) + 2 * (n_rej - r), exp);
	endtask
	// ****************
	// Scenarios
	// ****************
	initial begin
		#2000000;
		failures++;
		print_verdict();
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		#2 rst_n = 1'b1;
		repeat (4) @(posedge clk_sys);
		#2;
		check("mode", addr_mode_now, 0);
		check("top", address_top_byte, 0);
		setp(1, 0, 0, 4'h0);
		op({8'h20, 24'h0}, 32, 2);
		setp(0, 0, 0, 4'h0);
		op({8'h20, 24'h0}, 32, 1);
		check("kind", cmd_kind, 2);
		setp(0, 0, 0, 4'h9);
		op({8'hC5, 8'h01}, 16, 0);
		check("top", address_top_byte, 1);
		op({8'h20, 24'h123456}, 32, 2);
		op({8'hC5, 8'h00}, 16, 0);
		op({8'h20, 24'h123456}, 32, 1);
		check("addr", cmd_address, 32'h00123456);
		setp(0, 0, 1, 4'h9);
		op({8'hC5, 8'h01}, 16, 0);
		op({8'h20, 24'h123456}, 32, 1);
		check("addr", cmd_address, 32'h01123456);
		op({8'h20, 23'h0}, 31, 0);
		@(posedge clk_sys);
		#2 op_busy = 1'b1;
		op({8'h20, 24'h0}, 32, 0);
		u_host.frame({8'h05, 8'h00}, 16);
		check("status", n_stat, 1);
		@(posedge clk_sys);
		#2 op_busy = 1'b0;
		u_host.frame(64'hB7, 8);
		check("mode", addr_mode_now, 1);
		for (int k = 0; k < 24; k++) begin
			ra = $random(seed);
			setp(0, ra[31], ra[30], ra[29:26]);
			ra[31:25] = 7'h0;
			op({8'h21, ra}, 40, prot(ra[24:16]) ? 2 : 1);
			check("top", address_top_byte, ra[31:24]);
		end
		setp(0, 0, 0, 4'h0);
		for (int j = 0; j < 5; j++) begin
			op({ops[j], 40'h0} >> (48 - lens[j]), lens[j], 1);
			check("kind", cmd_kind, j + 1);
			check("opcode", cmd_opcode, ops[j]);
			check("latch", write_enabled, 0);
		end
		setp(0, 0, 1, 4'h1);
		op(64'h60, 8, 2);
		op({8'hDC, 32'h00010000}, 40, 1);
		u_host.frame(64'hE9, 8);
		check("mode", addr_mode_now, 0);
		op({8'hDC, 32'h01000000}, 40, 1);
		check("top", address_top_byte, 1);
		setp(1, 0, 0, 4'h9);
		op(64'h98, 8, 0);
		op({8'h20, 24'h0}, 32, 1);
		op({8'h36, 24'h0}, 32, 0);
		op({8'h20, 24'h0}, 32, 2);
		op({8'h39, 24'h0}, 32, 0);
		op({8'h20, 24'h0}, 32, 1);
		op(64'h7E, 8, 0);
		op({8'h20, 24'h0}, 32, 2);
		@(posedge clk_sys);
		#2 rst_n = 1'b0;
		addr_mode_at_power_on = 1'b1;
		repeat (3) @(posedge clk_sys);
		#2 rst_n = 1'b1;
		repeat (4) @(posedge clk_sys);
		#2;
		check("mode", addr_mode_now, 1);
		check("top", address_top_byte, 0);
		print_verdict();
	end
endmodule
